//--- rtl/ccdsm_pkg.sv
// constants, encodings and carrier types of the core data-space block
//
// Behaviour
// [RL1] reset after reset pin low two cycles
// [RL2] thirty-two eight-bit working registers, single-cycle access
// [RL3] two operands out, result back, one cycle
// [RL4] three 16-bit pointers; one addresses program constants
// [RL5] registers fill data addresses 00 to 1F
// [RL6] 64 I/O locations, direct or at 20-5F
// [RL7] two-stage fetch pipeline, one instruction per cycle
// [RL8] relative jumps and calls reach all program words
// [RL9] 16-bit program words; instructions one or two
// [RL10] calls and interrupts push return address to SRAM
// [RL11] eight-bit stack pointer readable, writable in I/O
// [RL12] software sets stack pointer before calls, interrupts
// [RL13] 128 SRAM bytes, five data addressing modes
// [RL14] idle halts execution, the rest keeps running
// [RL15] power-down keeps registers, stops oscillator until wake
// [RL16] SRAM sits just above the I/O region
package ccdsm_pkg;

  // --------------------
  // sizes and timing
  // --------------------
  localparam int PC_W           = 10;   // 1K program words
  localparam int SRAM_BYTES     = 128;
  localparam int REG_COUNT      = 32;
  localparam int RST_LOW_CYCLES = 2;    // machine cycles of low reset pin
  localparam int RESET_VECTOR   = 0;

  // --------------------
  // data-space map
  // --------------------
  localparam logic [15:0] REG_TOP   = 16'h001F;
  localparam logic [15:0] IO_BASE   = 16'h0020;
  localparam logic [15:0] IO_TOP    = 16'h005F;
  localparam logic [15:0] SRAM_BASE = 16'h0060;
  localparam logic [5:0]  SP_IO     = 6'h3D;    // stack pointer in I/O space
  localparam logic [15:0] SP_DADDR  = 16'h005D; // same location in data space
  localparam logic [4:0]  X_LO      = 5'h1A;
  localparam logic [4:0]  Y_LO      = 5'h1C;
  localparam logic [4:0]  Z_LO      = 5'h1E;

  // --------------------
  // encodings
  // --------------------
  typedef enum logic [3:0] {
    OP_NOP   = 4'h0,
    OP_ALU   = 4'h1,
    OP_LD    = 4'h2,
    OP_ST    = 4'h3,
    OP_LDS   = 4'h4,
    OP_STS   = 4'h5,
    OP_IN    = 4'h6,
    OP_OUT   = 4'h7,
    OP_RJMP  = 4'h8,
    OP_RCALL = 4'h9,
    OP_RET   = 4'hA,
    OP_LPM   = 4'hB,
    OP_SLEEP = 4'hC
  } ccdsm_op_t;

  typedef enum logic [2:0] {
    FN_ADD = 3'h0,
    FN_SUB = 3'h1,
    FN_AND = 3'h2,
    FN_OR  = 3'h3,
    FN_XOR = 3'h4,
    FN_MOV = 3'h5
  } ccdsm_fn_t;

  typedef enum logic [1:0] {
    PTR_X = 2'h0,
    PTR_Y = 2'h1,
    PTR_Z = 2'h2
  } ccdsm_ptr_t;

  typedef enum logic [1:0] {
    PM_PLAIN   = 2'h0,
    PM_POSTINC = 2'h1,
    PM_PREDEC  = 2'h2,
    PM_DISP    = 2'h3
  } ccdsm_pmode_t;

  typedef enum logic [5:0] {
    ST_RUN   = 6'b000001,
    ST_WORD2 = 6'b000010,
    ST_IORD  = 6'b000100,
    ST_LPM   = 6'b001000,
    ST_IDLE  = 6'b010000,
    ST_PDOWN = 6'b100000
  } ccdsm_state_t;

  // decoded operation handed in by the instruction decoder
  typedef struct packed {
    ccdsm_op_t         op;
    logic [4:0]        rd;      // destination, or data register of a transfer
    logic [4:0]        rr;
    ccdsm_fn_t         fn;
    logic              use_imm;
    logic [7:0]        imm;
    ccdsm_ptr_t        ptr;
    ccdsm_pmode_t      pmode;
    logic [5:0]        disp;
    logic [5:0]        io_addr;
    logic [PC_W-1:0]   rel;     // two's complement word offset
  } ccdsm_exec_t;

endpackage

//--- rtl/ccdsm_core.sv
// core register file, data-space map, fetch pipeline, stack and sleep control
module ccdsm_core #(
  parameter int PC_W       = ccdsm_pkg::PC_W,
  parameter int SRAM_BYTES = ccdsm_pkg::SRAM_BYTES
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   resetn,
  input  wire logic                   reset_pin_n,
  // program memory
  output logic [PC_W-1:0]             pmem_addr_r,
  input  wire logic [15:0]            pmem_data,
  // decoder
  output logic [15:0]                 instr_r,
  output logic                        instr_valid_r,
  input  wire ccdsm_pkg::ccdsm_exec_t exec_in,
  // peripheral I/O registers
  output logic [5:0]                  io_addr_r,
  output logic [7:0]                  io_wdata_r,
  output logic                        io_we_r,
  output logic                        io_re_r,
  input  wire logic [7:0]             io_rdata,
  // interrupts, sleep and core reset
  input  wire logic                   irq_req,
  input  wire logic [PC_W-1:0]        irq_vector,
  input  wire logic                   sleep_pdown,
  output logic                        irq_ack_r,
  output logic                        cpu_halt_r,
  output logic                        osc_stop_r,
  output logic                        core_reset_r
);
  localparam int          RAM_AW   = $clog2(SRAM_BYTES);
  localparam logic [15:0] SRAM_END = 16'(ccdsm_pkg::SRAM_BASE + 16'(SRAM_BYTES));
  localparam logic [1:0]  RST_CNT  = 2'(ccdsm_pkg::RST_LOW_CYCLES);
  // --------------------
  // storage
  // --------------------
  logic [7:0] regs [ccdsm_pkg::REG_COUNT];  // [RL2]
  logic [7:0] ram  [SRAM_BYTES];
  ccdsm_pkg::ccdsm_state_t state_r;
  ccdsm_pkg::ccdsm_exec_t  ex;
  logic                    rst_meta_r, rst_sync_r, srst, pend_st_r, pend_sel_r;
  logic [1:0]              low_cnt_r;
  logic [PC_W-1:0]         exec_pc_r, lpm_ret_r, target;
  logic [4:0]              pend_rd_r, ptr_base, acc_reg;
  logic [7:0]              sp_r, opa, opb, alu_res, st_data, acc_rdata, sp_m1, sp_p1, sp_p2;
  // combinational terms
  logic                    irq_take, go, adv, ptr_wb, acc_ld, acc_st, io_wait, push, pop;
  logic                    hit_reg, hit_io, hit_sp, hit_ram, redirect;
  logic [15:0]             ptr_val, ptr_eff, ptr_upd, z_val, acc_addr, io_off;
  logic [15:0]             push_pc16, pop_pc16;

  assign ex = exec_in;
  // data address lies in SRAM
  function automatic logic in_ram(input logic [15:0] a);
    return (a >= ccdsm_pkg::SRAM_BASE) && (a < SRAM_END);
  endfunction
  // SRAM array index of a data address
  function automatic logic [RAM_AW-1:0] ridx(input logic [15:0] a);
    return RAM_AW'(a - ccdsm_pkg::SRAM_BASE);
  endfunction
  // --------------------
  // reset pin qualification
  // --------------------
  // pin is synchronised, then must stay low for the full count
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rst_meta_r   <= 1'b1;
      rst_sync_r   <= 1'b1;
      low_cnt_r    <= 2'h0;
      core_reset_r <= 1'b1;
    end else begin
      rst_meta_r   <= reset_pin_n;
      rst_sync_r   <= rst_meta_r;
      if (rst_sync_r)
        low_cnt_r <= 2'h0;
      else if (low_cnt_r != RST_CNT)
        low_cnt_r <= low_cnt_r + 2'h1;
      core_reset_r <= (low_cnt_r == RST_CNT);  // [RL1]
    end
  end
  assign srst = !resetn || core_reset_r;
  // --------------------
  // operands, pointers and data-space decode
  // --------------------
  // sequencing conditions
  always_comb begin
    irq_take = irq_req && !srst &&
               ((state_r == ccdsm_pkg::ST_RUN && instr_valid_r) ||
                state_r == ccdsm_pkg::ST_IDLE || state_r == ccdsm_pkg::ST_PDOWN);  // [RL14] [RL15]
    go  = (state_r == ccdsm_pkg::ST_RUN) && instr_valid_r && !irq_take && !srst;
    adv = (state_r == ccdsm_pkg::ST_RUN && !irq_take) || state_r == ccdsm_pkg::ST_WORD2;
  end
  // two register operands into the ALU in one cycle
  always_comb begin
    opa = regs[ex.rd];  // [RL3]
    opb = ex.use_imm ? ex.imm : regs[ex.rr];
    case (ex.fn)
      ccdsm_pkg::FN_ADD: alu_res = opa + opb;
      ccdsm_pkg::FN_SUB: alu_res = opa - opb;
      ccdsm_pkg::FN_AND: alu_res = opa & opb;
      ccdsm_pkg::FN_OR:  alu_res = opa | opb;
      ccdsm_pkg::FN_XOR: alu_res = opa ^ opb;
      default:           alu_res = opb;
    endcase
  end
  // indirect pointer pairs and their addressing modes
  always_comb begin
    case (ex.ptr)
      ccdsm_pkg::PTR_X: ptr_base = ccdsm_pkg::X_LO;  // [RL4]
      ccdsm_pkg::PTR_Y: ptr_base = ccdsm_pkg::Y_LO;
      default:          ptr_base = ccdsm_pkg::Z_LO;
    endcase
    ptr_val = {regs[{ptr_base[4:1], 1'b1}], regs[ptr_base]};
    z_val   = {regs[{ccdsm_pkg::Z_LO[4:1], 1'b1}], regs[ccdsm_pkg::Z_LO]};
    ptr_eff = ptr_val;
    ptr_upd = ptr_val;
    ptr_wb  = 1'b0;
    case (ex.pmode)
      ccdsm_pkg::PM_POSTINC: begin  // [RL13]
        ptr_upd = ptr_val + 16'h0001;
        ptr_wb  = 1'b1;
      end
      ccdsm_pkg::PM_PREDEC: begin
        ptr_eff = ptr_val - 16'h0001;
        ptr_upd = ptr_eff;
        ptr_wb  = 1'b1;
      end
      ccdsm_pkg::PM_DISP: ptr_eff = ptr_val + {10'h000, ex.disp};
      default: ;
    endcase
  end
  // one data-space access per cycle, from any addressing mode
  always_comb begin
    acc_ld   = 1'b0;
    acc_st   = 1'b0;
    acc_addr = ptr_eff;
    acc_reg  = ex.rd;
    if (state_r == ccdsm_pkg::ST_WORD2 && !srst) begin
      acc_ld   = !pend_st_r;  // [RL9]
      acc_st   = pend_st_r;
      acc_addr = instr_r;
      acc_reg  = pend_rd_r;
    end else if (go) begin
      case (ex.op)
        ccdsm_pkg::OP_LD:  acc_ld = 1'b1;
        ccdsm_pkg::OP_ST:  acc_st = 1'b1;
        ccdsm_pkg::OP_IN: begin
          acc_ld   = 1'b1;
          acc_addr = {10'h000, ex.io_addr} + ccdsm_pkg::IO_BASE;  // [RL6]
        end
        ccdsm_pkg::OP_OUT: begin
          acc_st   = 1'b1;
          acc_addr = {10'h000, ex.io_addr} + ccdsm_pkg::IO_BASE;
        end
        default: ;
      endcase
    end
    st_data = regs[acc_reg];
    hit_reg = acc_addr <= ccdsm_pkg::REG_TOP;  // [RL5]
    hit_io  = acc_addr >= ccdsm_pkg::IO_BASE && acc_addr <= ccdsm_pkg::IO_TOP;  // [RL6]
    hit_sp  = acc_addr == ccdsm_pkg::SP_DADDR;  // [RL11]
    hit_ram = in_ram(acc_addr);  // [RL16]
    io_off  = acc_addr - ccdsm_pkg::IO_BASE;
    if (hit_reg)
      acc_rdata = regs[acc_addr[4:0]];
    else if (hit_sp)
      acc_rdata = sp_r;
    else if (hit_ram)
      acc_rdata = ram[ridx(acc_addr)];
    else
      acc_rdata = 8'h00;  // unmapped reads as zero
    io_wait = acc_ld && hit_io && !hit_sp;
  end
  // --------------------
  // stack and flow control
  // --------------------
  always_comb begin
    push      = irq_take || (go && ex.op == ccdsm_pkg::OP_RCALL);  // [RL10]
    pop       = go && ex.op == ccdsm_pkg::OP_RET;
    push_pc16 = irq_take ? 16'(exec_pc_r) : 16'(exec_pc_r + PC_W'(1));
    sp_m1     = sp_r - 8'h01;
    sp_p1     = sp_r + 8'h01;
    sp_p2     = sp_r + 8'h02;
    pop_pc16[15:8] = in_ram({8'h00, sp_p1}) ? ram[ridx({8'h00, sp_p1})] : 8'h00;
    pop_pc16[7:0]  = in_ram({8'h00, sp_p2}) ? ram[ridx({8'h00, sp_p2})] : 8'h00;
    redirect = irq_take || (go && (ex.op == ccdsm_pkg::OP_RJMP ||
                                   ex.op == ccdsm_pkg::OP_RCALL || pop));
    if (irq_take)
      target = irq_vector;
    else if (pop)
      target = pop_pc16[PC_W-1:0];
    else
      target = exec_pc_r + PC_W'(1) + ex.rel;  // [RL8] wraps over the whole space
  end
  // --------------------
  // sequencer
  // --------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= ccdsm_pkg::ST_RUN;
    end else begin
      case (state_r)
        ccdsm_pkg::ST_RUN: begin
          if (go) begin
            case (ex.op)
              ccdsm_pkg::OP_LDS, ccdsm_pkg::OP_STS: state_r <= ccdsm_pkg::ST_WORD2;  // [RL9]
              ccdsm_pkg::OP_LPM:   state_r <= ccdsm_pkg::ST_LPM;
              ccdsm_pkg::OP_SLEEP: state_r <= sleep_pdown ? ccdsm_pkg::ST_PDOWN
                                                          : ccdsm_pkg::ST_IDLE;  // [RL14] [RL15]
              default:             state_r <= io_wait ? ccdsm_pkg::ST_IORD : ccdsm_pkg::ST_RUN;
            endcase
          end
        end
        ccdsm_pkg::ST_WORD2: state_r <= io_wait ? ccdsm_pkg::ST_IORD : ccdsm_pkg::ST_RUN;
        ccdsm_pkg::ST_IDLE, ccdsm_pkg::ST_PDOWN: if (irq_take) state_r <= ccdsm_pkg::ST_RUN;
        default:             state_r <= ccdsm_pkg::ST_RUN;
      endcase
    end
  end
  // pending destination of multi-cycle transfers
  always_ff @(posedge clock) begin
    if (srst) begin
      pend_rd_r  <= 5'h00;
      pend_st_r  <= 1'b0;
      pend_sel_r <= 1'b0;
    end else if (go && (ex.op == ccdsm_pkg::OP_LDS || ex.op == ccdsm_pkg::OP_STS)) begin
      pend_rd_r <= ex.rd;
      pend_st_r <= ex.op == ccdsm_pkg::OP_STS;
    end else if (go && ex.op == ccdsm_pkg::OP_LPM) begin
      pend_rd_r  <= ex.rd;
      pend_sel_r <= z_val[0];  // byte of the word
    end else if (io_wait)
      pend_rd_r <= acc_reg;
  end
  // --------------------
  // fetch pipeline
  // --------------------
  // next word is fetched while the current one executes
  always_ff @(posedge clock) begin
    if (srst) begin
      pmem_addr_r   <= PC_W'(ccdsm_pkg::RESET_VECTOR);
      instr_r       <= 16'h0000;
      instr_valid_r <= 1'b0;
      exec_pc_r     <= PC_W'(ccdsm_pkg::RESET_VECTOR);
      lpm_ret_r     <= PC_W'(ccdsm_pkg::RESET_VECTOR);
    end else if (redirect) begin
      pmem_addr_r   <= target;  // prefetched word is dropped
      instr_valid_r <= 1'b0;
    end else if (state_r == ccdsm_pkg::ST_LPM) begin
      pmem_addr_r <= lpm_ret_r;  // resume fetching after the table read
    end else if (adv) begin
      instr_r       <= pmem_data;  // [RL7]
      instr_valid_r <= 1'b1;
      exec_pc_r     <= pmem_addr_r;
      pmem_addr_r   <= pmem_addr_r + PC_W'(1);
      if (go && ex.op == ccdsm_pkg::OP_LPM) begin
        lpm_ret_r   <= pmem_addr_r + PC_W'(1);
        pmem_addr_r <= z_val[PC_W:1];  // [RL4] constant lookup through Z
      end
    end
  end
  // --------------------
  // register file writes
  // --------------------
  // contents survive reset and power-down
  always_ff @(posedge clock) begin
    if (!srst) begin
      if (go && ex.op == ccdsm_pkg::OP_ALU)
        regs[ex.rd] <= alu_res;  // [RL3]
      if (go && ptr_wb && (ex.op == ccdsm_pkg::OP_LD || ex.op == ccdsm_pkg::OP_ST)) begin
        regs[ptr_base]                <= ptr_upd[7:0];  // [RL13]
        regs[{ptr_base[4:1], 1'b1}] <= ptr_upd[15:8];
      end
      if (acc_ld && !io_wait)
        regs[acc_reg] <= acc_rdata;
      if (acc_st && hit_reg)
        regs[acc_addr[4:0]] <= st_data;  // [RL5]
      if (state_r == ccdsm_pkg::ST_IORD)
        regs[pend_rd_r] <= io_rdata;
      if (state_r == ccdsm_pkg::ST_LPM)
        regs[pend_rd_r] <= pend_sel_r ? pmem_data[15:8] : pmem_data[7:0];
    end
  end
  // --------------------
  // data SRAM and stack
  // --------------------
  // stores and return-address pushes; the two never meet in a cycle
  always_ff @(posedge clock) begin
    if (!srst) begin
      if (acc_st && hit_ram)
        ram[ridx(acc_addr)] <= st_data;  // [RL16]
      if (push) begin
        if (in_ram({8'h00, sp_r}))
          ram[ridx({8'h00, sp_r})] <= push_pc16[7:0];  // [RL10]
        if (in_ram({8'h00, sp_m1}))
          ram[ridx({8'h00, sp_m1})] <= push_pc16[15:8];
      end
    end
  end
  // stack pointer, cleared at reset until software sets it
  always_ff @(posedge clock) begin
    if (srst)
      sp_r <= 8'h00;  // [RL12]
    else if (push)
      sp_r <= sp_r - 8'h02;
    else if (pop)
      sp_r <= sp_p2;
    else if (acc_st && hit_sp)
      sp_r <= st_data;  // [RL11]
  end
  // --------------------
  // peripheral port and status
  // --------------------
  // I/O accesses other than the stack pointer go outside
  always_ff @(posedge clock) begin
    if (srst) begin
      io_addr_r  <= 6'h00;
      io_wdata_r <= 8'h00;
      io_we_r    <= 1'b0;
      io_re_r    <= 1'b0;
    end else begin
      io_we_r <= acc_st && hit_io && !hit_sp;  // [RL6]
      io_re_r <= io_wait;
      if ((acc_st || acc_ld) && hit_io && !hit_sp) begin
        io_addr_r  <= io_off[5:0];
        io_wdata_r <= st_data;
      end
    end
  end
  // sleep indication and interrupt acknowledge
  always_ff @(posedge clock) begin
    if (srst) begin
      irq_ack_r  <= 1'b0;
      cpu_halt_r <= 1'b0;
      osc_stop_r <= 1'b0;
    end else begin
      irq_ack_r <= irq_take;
      if (irq_take || (go && ex.op == ccdsm_pkg::OP_SLEEP)) begin
        cpu_halt_r <= !irq_take;  // [RL14]
        osc_stop_r <= !irq_take && sleep_pdown;  // [RL15]
      end
    end
  end

endmodule // ccdsm_core

//--- sim/ccdsm_core_monitor.sv
// assertion checker for the core data-space block, bound to its ports
module ccdsm_core_mon #(
  parameter int PC_W = ccdsm_pkg::PC_W
) (
  // clock and reset
  input wire logic            clock,
  input wire logic            resetn,
  input wire logic            reset_pin_n,
  // program fetch
  input wire logic [PC_W-1:0] pmem_addr_r,
  input wire logic [15:0]     pmem_data,
  input wire logic [15:0]     instr_r,
  input wire logic            instr_valid_r,
  // peripheral bus
  input wire logic [5:0]      io_addr_r,
  input wire logic            io_we_r,
  input wire logic            io_re_r,
  // interrupt, sleep and reset state
  input wire logic [PC_W-1:0] irq_vector,
  input wire logic            irq_ack_r,
  input wire logic            cpu_halt_r,
  input wire logic            osc_stop_r,
  input wire logic            core_reset_r
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // clocking and named steps
  // ------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  // acknowledge with the vector on the fetch bus and an empty slot
  sequence s_vector_out;
    irq_ack_r && !instr_valid_r && pmem_addr_r == $past(irq_vector);
  endsequence
  // the vector word becomes the valid instruction
  sequence s_vector_in;
    instr_valid_r && instr_r == $past(pmem_data);
  endsequence

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_irq_vector_fetch: assert property (
    irq_ack_r |-> s_vector_out ##1 s_vector_in)
    else $error("interrupt vector not fetched in order");
  a_ack_single_pulse: assert property (
    irq_ack_r |=> !irq_ack_r)
    else $error("interrupt acknowledge longer than one cycle");
  a_io_read_stall: assert property (
    io_re_r |=> !io_re_r && $stable(pmem_addr_r))
    else $error("peripheral read strobe or fetch stall wrong");
  a_sp_off_bus: assert property (
    (io_we_r || io_re_r) |-> io_addr_r != ccdsm_pkg::SP_IO)
    else $error("stack pointer access seen on peripheral bus");
  a_fetch_step_one: assert property (
    $rose(instr_valid_r) |-> pmem_addr_r == $past(pmem_addr_r) + 1'b1)
    else $error("fetch did not step after refill");
  a_halt_fetch_frozen: assert property (
    cpu_halt_r |=> $stable(pmem_addr_r) || irq_ack_r || core_reset_r)
    else $error("fetch moved while halted");
  a_pdown_halts_cpu: assert property (
    osc_stop_r |-> cpu_halt_r)
    else $error("oscillator stopped without cpu halt");
  a_pin_reset_taken: assert property (
    !reset_pin_n [*5] |-> ##[0:2] core_reset_r)
    else $error("held reset pin did not reset the core");
  a_pin_high_runs: assert property (
    (reset_pin_n && resetn) [*6] |-> !core_reset_r)
    else $error("core held in reset with pin high");
endmodule // ccdsm_core_mon

bind ccdsm_core ccdsm_core_mon #(.PC_W(PC_W)) u_mon (
  .clock, .resetn, .reset_pin_n, .pmem_addr_r, .pmem_data, .instr_r, .instr_valid_r,
  .io_addr_r, .io_we_r, .io_re_r, .irq_vector, .irq_ack_r, .cpu_halt_r, .osc_stop_r,
  .core_reset_r
);

//--- sim/ccdsm_far_model.sv
// program flash and peripheral register model facing the core
module ccdsm_far_model #(
  parameter int PC_W = ccdsm_pkg::PC_W
) (
  // clock
  input  wire logic            clock,
  // program memory
  input  wire logic [PC_W-1:0] pmem_addr_r,
  output logic [15:0]          pmem_data,
  // peripheral registers
  input  wire logic [5:0]      io_addr_r,
  input  wire logic [7:0]      io_wdata_r,
  input  wire logic            io_we_r,
  input  wire logic            io_re_r,
  output logic [7:0]           io_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pmem [2**PC_W];
  logic [7:0]  io_mem [64];

  // flash answers in the same cycle, one 16-bit word per address
  assign pmem_data = pmem[pmem_addr_r];
  // read data valid only in the strobe cycle, inverted otherwise
  assign io_rdata = io_re_r ? io_mem[io_addr_r] : ~io_mem[io_addr_r];

  // peripheral register write, bench may preload too
  always @(posedge clock) begin
    if (io_we_r) begin
      io_mem[io_addr_r] <= io_wdata_r;
    end
  end
endmodule // ccdsm_far_model

//--- sim/tb.sv
// self-checking bench for the core data-space block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clock, resetn, reset_pin_n, irq_req, sleep_pdown;
  logic                   instr_valid_r, io_we_r, io_re_r, irq_ack_r;
  logic                   cpu_halt_r, osc_stop_r, core_reset_r;
  logic [9:0]             pmem_addr_r, irq_vector;
  logic [15:0]            pmem_data, instr_r;
  logic [5:0]             io_addr_r;
  logic [7:0]             io_wdata_r, io_rdata;
  ccdsm_pkg::ccdsm_exec_t exec_in;
  ccdsm_pkg::ccdsm_exec_t dec [64];
  int                     mismatches, check_count;

  ccdsm_core u_dut (
    .clock, .resetn, .reset_pin_n, .pmem_addr_r, .pmem_data, .instr_r, .instr_valid_r,
    .exec_in, .io_addr_r, .io_wdata_r, .io_we_r, .io_re_r, .io_rdata, .irq_req,
    .irq_vector, .sleep_pdown, .irq_ack_r, .cpu_halt_r, .osc_stop_r, .core_reset_r
  );
  ccdsm_far_model u_far (
    .clock, .pmem_addr_r, .pmem_data, .io_addr_r, .io_wdata_r, .io_we_r, .io_re_r,
    .io_rdata
  );

  // clock and decoder: low six word bits index the decode table
  always #5 clock = ~clock;
  assign exec_in = dec[instr_r[5:0]];

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // place one decoded word at a program address
  task automatic put(input logic [9:0] a, input logic [3:0] op, input logic [4:0] rd,
                     input logic [9:0] x, input logic [11:0] y);
    ccdsm_pkg::ccdsm_exec_t e;
    e = '0;
    e.op = ccdsm_pkg::ccdsm_op_t'(op);
    e.rd = rd;
    e.rr = x[4:0];
    e.io_addr = x[5:0];
    e.rel = x;
    e.imm = y[7:0];
    e.fn = ccdsm_pkg::ccdsm_fn_t'(y[10:8]);
    e.use_imm = y[11];
    e.pmode = ccdsm_pkg::ccdsm_pmode_t'(y[9:8]);
    u_far.pmem[a] = {10'h000, a[5:0]};
    dec[a[5:0]] = e;
  endtask

  task automatic load_program();
    for (int i = 0; i < 1024; i++) u_far.pmem[i] = 16'h003F;
    for (int i = 0; i < 64; i++) dec[i] = '0;
    for (int i = 0; i < 64; i++) u_far.io_mem[i] = 8'h00;
    u_far.io_mem[7] = 8'h5A;
    // arithmetic, pointer and data-space accesses
    put(10'h000, 4'h1, 5'h01, 10'h000, 12'hD35);
    put(10'h001, 4'h1, 5'h02, 10'h000, 12'hD0A);
    put(10'h002, 4'h1, 5'h01, 10'h002, 12'h000);
    put(10'h003, 4'h7, 5'h01, 10'h001, 12'h000);
    put(10'h004, 4'h1, 5'h1A, 10'h000, 12'hD60);
    put(10'h005, 4'h1, 5'h1B, 10'h000, 12'hD00);
    put(10'h006, 4'h3, 5'h01, 10'h000, 12'h100);
    put(10'h007, 4'h5, 5'h01, 10'h000, 12'h000);
    u_far.pmem[10'h008] = 16'h0005;
    put(10'h009, 4'h5, 5'h02, 10'h000, 12'h000);
    u_far.pmem[10'h00A] = 16'h0030;
    put(10'h00B, 4'h2, 5'h06, 10'h000, 12'h200);
    put(10'h00C, 4'h1, 5'h06, 10'h005, 12'h000);
    put(10'h00D, 4'h7, 5'h06, 10'h002, 12'h000);
    put(10'h00E, 4'h6, 5'h07, 10'h007, 12'h000);
    put(10'h00F, 4'h7, 5'h07, 10'h003, 12'h000);
    // software sets the stack pointer before any call
    put(10'h010, 4'h1, 5'h08, 10'h000, 12'hDC0);
    put(10'h011, 4'h7, 5'h08, 10'h03D, 12'h000);
    put(10'h012, 4'h6, 5'h09, 10'h03D, 12'h000);
    put(10'h013, 4'h7, 5'h09, 10'h004, 12'h000);
    // call, return, sleeps and far jumps
    put(10'h014, 4'h9, 5'h00, 10'h013, 12'h000);
    put(10'h015, 4'h7, 5'h01, 10'h006, 12'h000);
    put(10'h016, 4'h4, 5'h0A, 10'h000, 12'h000);
    u_far.pmem[10'h017] = 16'h00C0;
    put(10'h018, 4'h7, 5'h0A, 10'h007, 12'h000);
    put(10'h019, 4'hC, 5'h00, 10'h000, 12'h000);
    put(10'h01A, 4'h7, 5'h01, 10'h008, 12'h000);
    put(10'h01B, 4'h8, 5'h00, 10'h3E0, 12'h000);
    put(10'h3FC, 4'h7, 5'h02, 10'h00A, 12'h000);
    put(10'h3FD, 4'h8, 5'h00, 10'h01F, 12'h000);
    put(10'h01D, 4'hC, 5'h00, 10'h000, 12'h000);
    put(10'h01E, 4'h8, 5'h00, 10'h3FF, 12'h000);
    put(10'h028, 4'h7, 5'h02, 10'h005, 12'h000);
    put(10'h029, 4'hA, 5'h00, 10'h000, 12'h000);
    put(10'h030, 4'h7, 5'h02, 10'h009, 12'h000);
    put(10'h031, 4'hA, 5'h00, 10'h000, 12'h000);
  endtask

  // compare one observed value with its expected value
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic timeout(input string what);
    mismatches++;
    $display("unexpected %s: expected event, seen timeout", what);
    finish_test();
  endtask

  function automatic logic sig(input int sel);
    case (sel)
      0: return cpu_halt_r;
      1: return core_reset_r;
      default: return irq_ack_r;
    endcase
  endfunction

  // bounded wait at falling edges for a flag level
  task automatic wait_lvl(input string what, input int sel, input logic v);
    for (int n = 0; n < 300; n++) begin
      @(negedge clock);
      if (sig(sel) === v) return;
    end
    timeout(what);
  endtask

  // bounded wait for the next peripheral write, then compare it
  task automatic expect_io(input logic [5:0] a, input logic [7:0] d);
    for (int n = 0; n < 300; n++) begin
      @(negedge clock);
      if (io_we_r === 1'b1) begin
        chk("io address", {10'h000, a}, {10'h000, io_addr_r});
        chk("io data", {8'h00, d}, {8'h00, io_wdata_r});
        return;
      end
    end
    timeout("io write");
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_data_map();
    expect_io(6'h01, 8'h3F);
    expect_io(6'h10, 8'h0A);
    expect_io(6'h02, 8'h7E);
    expect_io(6'h03, 8'h5A);
    $display("test data_map done");
  endtask

  task automatic t_stack();
    expect_io(6'h04, 8'hC0);
    expect_io(6'h05, 8'h0A);
    expect_io(6'h06, 8'h3F);
    expect_io(6'h07, 8'h15);
    $display("test stack done");
  endtask

  // sleep, check the halt holds, then wake by interrupt
  task automatic wake(input logic pd);
    logic [9:0] a;
    wait_lvl("cpu halt", 0, 1'b1);
    a = pmem_addr_r;
    chk("oscillator stop", {15'h0000, pd}, {15'h0000, osc_stop_r});
    repeat (4) @(negedge clock);
    chk("halted fetch", {6'h00, a}, {6'h00, pmem_addr_r});
    irq_req = 1'b1;
    wait_lvl("irq ack", 2, 1'b1);
    irq_req = 1'b0;
    expect_io(6'h09, 8'h0A);
  endtask

  task automatic t_idle();
    wake(1'b0);
    expect_io(6'h08, 8'h3F);
    expect_io(6'h0A, 8'h0A);
    $display("test idle done");
  endtask

  task automatic t_pdown();
    sleep_pdown = 1'b1;
    wake(1'b1);
    $display("test pdown done");
  endtask

  // short pin glitch is ignored, a held pin restarts the program
  task automatic t_pin();
    reset_pin_n = 1'b0;
    @(negedge clock);
    reset_pin_n = 1'b1;
    repeat (8) @(negedge clock);
    chk("reset after glitch", 16'h0000, {15'h0000, core_reset_r});
    reset_pin_n = 1'b0;
    wait_lvl("core reset", 1, 1'b1);
    reset_pin_n = 1'b1;
    wait_lvl("core release", 1, 1'b0);
    expect_io(6'h01, 8'h3F);
    $display("test pin done");
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    reset_pin_n = 1'b1;
    irq_req = 1'b0;
    irq_vector = 10'h030;
    sleep_pdown = 1'b0;
    mismatches = 0;
    check_count = 0;
    load_program();
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    t_data_map();
    t_stack();
    t_idle();
    t_pdown();
    t_pin();
    finish_test();
  end
endmodule // tb
